// file: i2c_stat_pkg.sv
// constants, state type and read decoder shared by the status/mask block
`default_nettype none
package i2c_stat_pkg;
  // register byte addresses on the register bus
  localparam logic [3:0]  ADDR_STATUS  = 4'h0;
  localparam logic [3:0]  ADDR_MASK    = 4'h4;
  localparam logic [3:0]  ADDR_TXHOLD  = 4'h8;
  // status field positions
  localparam int          B_ACK        = 15;
  localparam int          B_TXACT      = 14;
  localparam int          B_BCL        = 10;
  localparam int          B_GC         = 9;
  localparam int          B_TEN        = 8;
  localparam int          B_WCOL       = 7;
  localparam int          B_OV         = 6;
  localparam int          B_DA         = 5;
  localparam int          B_STOP       = 4;
  // mask register layout and reset values
  localparam int          MASK_W       = 10;
  localparam logic [9:0]  MASK_RESET   = 10'h000;
  localparam logic [7:0]  TXHOLD_RESET = 8'h00;
  // last bit index of a master transmit (8 data bits + ack)
  localparam logic [3:0]  TX_LAST_BIT  = 4'h8;
  // first byte header of a 10-bit address
  localparam logic [4:0]  TEN_HEADER   = 5'h1e;
  // bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // whole state of the status/mask block
  typedef struct packed {
    logic       scl_s1, scl_s2, scl_d;  // scl synchroniser and delay
    logic       sda_s1, sda_s2, sda_d;  // sda synchroniser and delay
    logic       ack, txact;             // remote ack, transmit active
    logic [3:0] bit_cnt;                // bit index within a transmit
    logic       bus_collision_flag, gc, ten, wcol, ov, da, stop_last;
    logic       ten_pend;               // header byte of 10-bit matched
    logic [9:0] mask;                   // slave address mask bits
    logic [7:0] txd;                    // transmit holding register
    logic       txl;                    // load pulse to the engine
    logic       aw_h, w_h;              // address / data captured
    logic [3:0] awa;                    // captured write address
    logic       aw_bad;                 // captured address out of range
    logic [15:0] wd;                    // captured write data
    logic [1:0] ws;                     // captured low byte strobes
    logic       awr, wr, bv;            // channel handshakes
    logic [1:0] br;                     // write response code
    logic       arr, rv;                // read handshakes
    logic [31:0] rd;                    // read data
    logic [1:0] rr;                     // read response code
  } state_t;
  // read data for a word address; unused bits read zero
  function automatic logic [31:0] rd_word(input state_t s, input logic [3:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      ADDR_STATUS:
      begin
        v[B_ACK]   = s.ack;
        v[B_TXACT] = s.txact;
        v[B_BCL]   = s.bus_collision_flag;
        v[B_GC]    = s.gc;
        v[B_TEN]   = s.ten;
        v[B_WCOL]  = s.wcol;
        v[B_OV]    = s.ov;
        v[B_DA]    = s.da;
        v[B_STOP]  = s.stop_last;
      end
      ADDR_MASK:   v[9:0] = s.mask;
      ADDR_TXHOLD: v[7:0] = s.txd;
      default:     v = 32'h0000_0000;
    endcase
    return v;
  endfunction
endpackage
`default_nettype wire

// file: addr_compare.sv
// masked slave address comparison for 7-bit, 10-bit and general call
`timescale 1ns/1ps
`default_nettype none
module addr_compare
(
  // received address byte and configuration
  input  wire logic [7:0] addr_byte,
  input  wire logic [9:0] own_addr,
  input  wire logic [9:0] mask,
  input  wire logic       gc_enable,
  // comparison results
  output logic            hit7,
  output logic            gc_hit,
  output logic            hi_hit,
  output logic            lo_hit
);
  // 7-bit: mask bit i frees incoming address bit Ai, byte bit i+1
  assign hit7   = ((addr_byte[7:1] ^ own_addr[6:0]) & ~mask[6:0]) == 7'h00;
  // general call is the all-zero address
  assign gc_hit = gc_enable && (addr_byte[7:1] == 7'h00);
  // 10-bit header byte carries A9..A8 in bits 2..1
  assign hi_hit = (addr_byte[7:3] == i2c_stat_pkg::TEN_HEADER) &&
                  (((addr_byte[2:1] ^ own_addr[9:8]) & ~mask[9:8]) == 2'h0);
  // second byte carries A7..A0, one mask bit per position
  assign lo_hit = ((addr_byte ^ own_addr[7:0]) & ~mask[7:0]) == 8'h00;
endmodule
`default_nettype wire

// file: i2c_status_mask.sv
// two-wire bus status flags and slave address mask behind an AXI4-Lite slave
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module i2c_status_mask
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // bus pins, sampled
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  // bus engine events (same clock)
  input  wire logic        tx_begin,
  input  wire logic        collision,
  input  wire logic        engine_busy,
  input  wire logic        addr_valid,
  input  wire logic [7:0]  addr_byte,
  input  wire logic        ten_bit_mode,
  input  wire logic        gc_enable,
  input  wire logic [9:0]  own_addr,
  input  wire logic        slave_data_valid,
  input  wire logic        rx_transfer,
  input  wire logic        rx_holding_full,
  // transmit holding register toward the engine
  output logic [7:0]       tx_data,
  output logic             tx_load
);
  i2c_stat_pkg::state_t st;          // registered state
  i2c_stat_pkg::state_t next_st;     // next state
  logic [1:0]           rst_q;       // reset release synchroniser
  logic                 rst_n;       // synchronised reset
  logic                 scl_rise;    // scl rising edge, synchronised
  logic                 start_det;   // start or repeated start seen
  logic                 stop_det;    // stop seen
  logic                 hit7, gc_hit, hi_hit, lo_hit;
  logic                 wr_go;       // write committed this cycle
  logic                 tx_wr;       // write aimed at transmit holding
  logic                 busy;        // controller busy for transmit writes

  // assert asynchronously, release through two flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // comparator shares the mask register with the read path
  addr_compare u_cmp
  (
    .addr_byte (addr_byte),
    .own_addr  (own_addr),
    .mask      (st.mask),
    .gc_enable (gc_enable),
    .hit7      (hit7),
    .gc_hit    (gc_hit),
    .hi_hit    (hi_hit),
    .lo_hit    (lo_hit)
  );

  // edges on the bus use only the second synchroniser stage and its delayed copy
  assign scl_rise  = st.scl_s2 && !st.scl_d;
  assign start_det = st.scl_s2 && st.scl_d && st.sda_d && !st.sda_s2;
  assign stop_det  = st.scl_s2 && st.scl_d && !st.sda_d && st.sda_s2;
  assign wr_go     = st.aw_h && st.w_h && !st.bv;
  assign tx_wr     = wr_go && (st.awa == i2c_stat_pkg::ADDR_TXHOLD) && st.ws[0];
  assign busy      = engine_busy || st.txact;

  // next-state logic
  always_comb
  begin
    next_st        = st;
    next_st.scl_s1 = scl_in;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_d  = st.scl_s2;
    next_st.sda_s1 = sda_in;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_d  = st.sda_s2;
    next_st.txl    = 1'b0;

    // master transmit: count scl rises, ack sampled on the ninth
    if (st.txact && scl_rise)
    begin
      next_st.bit_cnt = st.bit_cnt + 4'h1;
      if (st.bit_cnt == i2c_stat_pkg::TX_LAST_BIT)
      begin
        next_st.ack   = st.sda_s2;
        next_st.txact = 1'b0;
      end
    end
    // a lost arbitration ends the transmit as well
    if (collision)
      next_st.txact = 1'b0;
    else if (tx_begin)
    begin
      next_st.txact   = 1'b1;
      next_st.bit_cnt = 4'h0;
    end

    // software clears: a 0 written to a clearable bit clears it
    if (wr_go && st.awa == i2c_stat_pkg::ADDR_STATUS)
    begin
      if (st.ws[1] && !st.wd[i2c_stat_pkg::B_BCL])
        next_st.bus_collision_flag = 1'b0;
      if (st.ws[0] && !st.wd[i2c_stat_pkg::B_WCOL])
        next_st.wcol = 1'b0;
      if (st.ws[0] && !st.wd[i2c_stat_pkg::B_OV])
        next_st.ov = 1'b0;
    end
    // hardware sets placed after clears so that a set wins
    if (collision)
      next_st.bus_collision_flag = 1'b1;
    if (tx_wr && busy)
      next_st.wcol = 1'b1;
    if (rx_transfer && rx_holding_full)
      next_st.ov = 1'b1;

    // bus conditions
    if (start_det)
      next_st.stop_last = 1'b0;
    if (stop_det)
    begin
      next_st.stop_last = 1'b1;
      next_st.gc        = 1'b0;
      next_st.ten       = 1'b0;
      next_st.ten_pend  = 1'b0;
    end

    // address bytes; 10-bit needs header then low byte
    if (addr_valid)
    begin
      if (gc_hit)
      begin
        next_st.gc = 1'b1;
        next_st.da = 1'b0;
      end
      else if (!ten_bit_mode && hit7)
        next_st.da = 1'b0;
      else if (ten_bit_mode && st.ten_pend)
      begin
        next_st.ten_pend = 1'b0;
        if (lo_hit)
        begin
          next_st.ten = 1'b1;
          next_st.da  = 1'b0;
        end
      end
      else if (ten_bit_mode && hi_hit)
        next_st.ten_pend = 1'b1;
    end
    if (slave_data_valid)
      next_st.da = 1'b1;

    // write address and data channels taken in either order
    if (s_axi_awvalid && st.awr)
    begin
      next_st.aw_h = 1'b1;
      next_st.awa  = {s_axi_awaddr[3:2], 2'b00};
      next_st.aw_bad = (s_axi_awaddr[31:4] != 28'h0) || (s_axi_awaddr[3:2] == 2'b11); // bus may move on
    end
    if (s_axi_wvalid && st.wr)
    begin
      next_st.w_h = 1'b1;
      next_st.wd  = s_axi_wdata[15:0];
      next_st.ws  = s_axi_wstrb[1:0];
    end
    if (wr_go)
    begin
      next_st.aw_h = 1'b0;
      next_st.w_h  = 1'b0;
      next_st.bv   = 1'b1;
      next_st.br   = st.aw_bad ? i2c_stat_pkg::RESP_SLVERR : i2c_stat_pkg::RESP_OKAY;
      if (st.awa == i2c_stat_pkg::ADDR_MASK)
      begin
        if (st.ws[0])
          next_st.mask[7:0] = st.wd[7:0];
        if (st.ws[1])
          next_st.mask[9:8] = st.wd[9:8];
      end
      if (tx_wr && !busy)
      begin
        next_st.txd = st.wd[7:0];
        next_st.txl = 1'b1;
      end
    end
    if (st.bv && s_axi_bready)
      next_st.bv = 1'b0;
    next_st.awr = !next_st.aw_h && !next_st.bv;
    next_st.wr  = !next_st.w_h && !next_st.bv;

    // read channel: one cycle to data, held until taken
    if (s_axi_arvalid && st.arr)
    begin
      next_st.rv = 1'b1;
      next_st.rd = i2c_stat_pkg::rd_word(st, {s_axi_araddr[3:2], 2'b00});
      next_st.rr = (s_axi_araddr[3:2] == 2'b11 || s_axi_araddr[31:4] != 28'h0) ?
                   i2c_stat_pkg::RESP_SLVERR : i2c_stat_pkg::RESP_OKAY;
    end
    else if (st.rv && s_axi_rready)
      next_st.rv = 1'b0;
    next_st.arr = !next_st.rv;
  end

  // one register for all state; pins idle high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st        <= '0;
      st.scl_s1 <= 1'b1;
      st.scl_s2 <= 1'b1;
      st.scl_d  <= 1'b1;
      st.sda_s1 <= 1'b1;
      st.sda_s2 <= 1'b1;
      st.sda_d  <= 1'b1;
      st.mask   <= i2c_stat_pkg::MASK_RESET;
      st.txd    <= i2c_stat_pkg::TXHOLD_RESET;
    end
    else
      st <= next_st;
  end

  // outputs straight from the state register
  assign s_axi_awready = st.awr;
  assign s_axi_wready  = st.wr;
  assign s_axi_bvalid  = st.bv;
  assign s_axi_bresp   = st.br;
  assign s_axi_arready = st.arr;
  assign s_axi_rvalid  = st.rv;
  assign s_axi_rdata   = st.rd;
  assign s_axi_rresp   = st.rr;
  assign tx_data       = st.txd;
  assign tx_load       = st.txl;

  // checks on the flags and on the mask read
  property p_ack;
    @(posedge clk) disable iff (!rst_n)
    (st.txact && scl_rise && st.bit_cnt == 4'h8 && !collision && !tx_begin)
      |=> (st.ack == $past(st.sda_s2) && !st.txact);
  endproperty
  a_ack: assert property (p_ack) else $error("ack not captured");

  property p_txact_span;
    @(posedge clk) disable iff (!rst_n)
    st.txact |-> st.bit_cnt <= 4'h8;
  endproperty
  a_txact_span: assert property (p_txact_span) else $error("transmit overran");

  property p_txact_set;
    @(posedge clk) disable iff (!rst_n)
    (tx_begin && !collision) |=> (st.txact && st.bit_cnt == 4'h0);
  endproperty
  a_txact_set: assert property (p_txact_set) else $error("transmit not started");

  property p_bcl;
    @(posedge clk) disable iff (!rst_n)
    collision |=> st.bus_collision_flag;
  endproperty
  a_bcl: assert property (p_bcl) else $error("collision lost");

  property p_stop_clear;
    @(posedge clk) disable iff (!rst_n)
    (stop_det && !addr_valid) |=> (!st.gc && !st.ten && st.stop_last);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear");

  property p_wcol;
    @(posedge clk) disable iff (!rst_n)
    (tx_wr && busy) |=> (st.wcol && !st.txl && $stable(st.txd));
  endproperty
  a_wcol: assert property (p_wcol) else $error("busy write not refused");

  property p_ov;
    @(posedge clk) disable iff (!rst_n)
    (rx_transfer && rx_holding_full) |=> st.ov;
  endproperty
  a_ov: assert property (p_ov) else $error("overflow missed");

  property p_data_kind;
    @(posedge clk) disable iff (!rst_n)
    (slave_data_valid) |=> st.da;
  endproperty
  a_data_kind: assert property (p_data_kind) else $error("data kind not set");

  property p_start;
    @(posedge clk) disable iff (!rst_n)
    start_det |=> !st.stop_last;
  endproperty
  a_start: assert property (p_start) else $error("start not recorded");

  property p_mask_read;
    @(posedge clk) disable iff (!rst_n)
    (s_axi_arvalid && st.arr && s_axi_araddr == {28'h000_0000, i2c_stat_pkg::ADDR_MASK})
      |=> (st.rv && st.rd[31:10] == 22'h00_0000 && st.rd[9:0] == $past(st.mask));
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

  c_tx_done: cover property (@(posedge clk) disable iff (!rst_n) st.txact ##1 !st.txact);
  c_ten_hit: cover property (@(posedge clk) disable iff (!rst_n) !st.ten ##1 st.ten);
  c_wcol:    cover property (@(posedge clk) disable iff (!rst_n) tx_wr && busy);
endmodule
`default_nettype wire

// file: bus_peer_model.sv
// behavioural peer on the two-wire bus: start, stop and clocked bits
`timescale 1ns/1ps
`default_nettype none
module bus_peer_model
(
  // wire levels; a released line sits at its pull-up level
  output var logic scl,
  output var logic sda
);
  // half period of the 160 ns link clock
  localparam time HALF = 80ns;
  // idle bus: both lines released, clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start: data falls while the clock is high
  task automatic start_c();
    #5;  // step off the block's sampling edge
    sda = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda = 1'b0;
    #HALF scl = 1'b0;
    #HALF;
  endtask
  // stop: data rises while the clock is high
  task automatic stop_c();
    #5;  // step off the block's sampling edge
    sda = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda = 1'b1;
    #HALF;
  endtask
  // one bit, data set up while the clock is low
  task automatic clock_bit(input logic b);
    sda = b;
    #HALF scl = 1'b1;
    #HALF scl = 1'b0;
  endtask
  // eight data bits then the slave acknowledge level (1 = nack)
  task automatic send9(input logic [7:0] d, input logic ack);
    #5;  // step off the block's sampling edge
    for (int i = 7; i >= 0; i--)
      clock_bit(d[i]);
    clock_bit(ack);
    sda = 1'b1;
    #HALF;
  endtask
endmodule
`default_nettype wire

// file: tb_i2c_status_mask.sv
// self-checking bench for status flags, address mask and transmit holding register
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_i2c_status_mask;
  // bench bookkeeping
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          loads = 0;
  // clock, reset and register bus master side
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  // engine events: tx begin, collision, address, slave data, rx transfer
  logic [4:0]  ev = '0;
  logic        engine_busy = 1'b0, ten_bit_mode = 1'b0, rx_holding_full = 1'b0;
  logic        gc_enable = 1'b1;
  logic [7:0]  addr_byte = '0, tx_data;
  logic [9:0]  own_addr = '0;
  logic        tx_load, scl, sda;
  localparam logic [31:0] A_ST = {28'h0, i2c_stat_pkg::ADDR_STATUS};
  localparam logic [31:0] A_MK = {28'h0, i2c_stat_pkg::ADDR_MASK};
  localparam logic [31:0] A_TX = {28'h0, i2c_stat_pkg::ADDR_TXHOLD};
  // address table rows; exp is {general call, ten-bit hit, last byte data}
  typedef struct packed {logic ten; logic [9:0] msk, own; logic [7:0] b0, b1;
    logic [2:0] exp;} row_t;
  row_t rows [10] = '{
    '{1'b0, 10'h000, 10'h052, 8'ha5, 8'h00, 3'h0},
    '{1'b0, 10'h000, 10'h052, 8'ha7, 8'h00, 3'h1},
    '{1'b0, 10'h001, 10'h052, 8'ha7, 8'h00, 3'h0},
    '{1'b0, 10'h002, 10'h052, 8'ha7, 8'h00, 3'h1},
    '{1'b0, 10'h000, 10'h052, 8'h00, 8'h00, 3'h4},
    '{1'b1, 10'h000, 10'h2b4, 8'hf4, 8'hb4, 3'h2},
    '{1'b1, 10'h000, 10'h2b4, 8'hf4, 8'hb5, 3'h1},
    '{1'b1, 10'h001, 10'h2b4, 8'hf4, 8'hb5, 3'h2},
    '{1'b1, 10'h002, 10'h2b4, 8'hf4, 8'hb5, 3'h1},
    '{1'b1, 10'h300, 10'h2b4, 8'hf0, 8'hb4, 3'h2}};
  // 50 MHz clock
  always #10 clk = ~clk;
  i2c_status_mask dut_u (.clk (clk), .resetn (resetn),
    .s_axi_awvalid (s_axi_awvalid), .s_axi_awready (s_axi_awready),
    .s_axi_awaddr (s_axi_awaddr), .s_axi_wvalid (s_axi_wvalid), .s_axi_wready (s_axi_wready),
    .s_axi_wdata (s_axi_wdata), .s_axi_wstrb (s_axi_wstrb), .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (1'b1), .s_axi_bresp (s_axi_bresp), .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready), .s_axi_araddr (s_axi_araddr),
    .s_axi_rvalid (s_axi_rvalid), .s_axi_rready (1'b1), .s_axi_rdata (s_axi_rdata),
    .s_axi_rresp (s_axi_rresp), .scl_in (scl), .sda_in (sda), .tx_begin (ev[0]),
    .collision (ev[1]), .engine_busy (engine_busy), .addr_valid (ev[2]),
    .addr_byte (addr_byte), .ten_bit_mode (ten_bit_mode), .gc_enable (gc_enable),
    .own_addr (own_addr), .slave_data_valid (ev[3]), .rx_transfer (ev[4]),
    .rx_holding_full (rx_holding_full), .tx_data (tx_data), .tx_load (tx_load));
  bus_peer_model peer (.scl (scl), .sda (sda));
  // verdict and end of run
  task automatic print_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well above the fewer than one thousand cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (tx_load === 1'b1)
      loads++;
    if (cycles == 8000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  // write: address and data offered together, each dropped when taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask
  // read: address held until taken, data taken at the rvalid edge
  task automatic axi_read(input logic [31:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // one-cycle engine event pulse
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    axi_read(A_ST);
    `CHK("status reset", 32'h0000_0000, rd)
    axi_read(A_MK);
    `CHK("mask reset", 32'h0000_0000, rd)
    `CHK("read resp", i2c_stat_pkg::RESP_OKAY, rsp)
    axi_write(A_MK, 32'hffff_ffff, 4'hf);
    `CHK("write resp", i2c_stat_pkg::RESP_OKAY, rsp)
    axi_read(A_MK);
    `CHK("mask upper", 32'h0000_03ff, rd)
    // address table: a stop clears last hits, data pulse sets the kind flag
    foreach (rows[i])
    begin
      peer.start_c();
      peer.stop_c();
      axi_write(A_MK, {22'h0, rows[i].msk}, 4'hf);
      ten_bit_mode <= rows[i].ten;
      own_addr <= rows[i].own;
      addr_byte <= rows[i].b0;
      if (rows[i].ten)
        pulse(5'h04);
      pulse(5'h08);
      addr_byte <= rows[i].ten ? rows[i].b1 : rows[i].b0;
      pulse(5'h04);
      axi_read(A_ST);
      `CHK("addr row", rows[i].exp, {rd[9], rd[8], rd[5]})
      `CHK("stop last", 1'b1, rd[i2c_stat_pkg::B_STOP])
    end
    // general call ignored while disabled
    gc_enable <= 1'b0;
    ten_bit_mode <= 1'b0;
    addr_byte <= 8'h00;
    pulse(5'h04);
    axi_read(A_ST);
    `CHK("gc disabled", 1'b0, rd[i2c_stat_pkg::B_GC])
    // master transmit with nack, then with ack
    peer.start_c();
    pulse(5'h01);
    axi_read(A_ST);
    `CHK("tx active", 1'b1, rd[i2c_stat_pkg::B_TXACT])
    `CHK("stop after start", 1'b0, rd[i2c_stat_pkg::B_STOP])
    peer.send9(8'h5a, 1'b1);
    axi_read(A_ST);
    `CHK("tx done", 1'b0, rd[i2c_stat_pkg::B_TXACT])
    `CHK("nack", 1'b1, rd[i2c_stat_pkg::B_ACK])
    pulse(5'h01);
    peer.send9(8'ha5, 1'b0);
    axi_read(A_ST);
    `CHK("ack", 1'b0, rd[i2c_stat_pkg::B_ACK])
    peer.stop_c();
    // collision, busy write and overflow are sticky until written with 0
    pulse(5'h02);
    engine_busy <= 1'b1;
    axi_write(A_TX, 32'h0000_005a, 4'hf);
    engine_busy <= 1'b0;
    rx_holding_full <= 1'b1;
    pulse(5'h10);
    axi_read(A_ST);
    `CHK("sticky set", 3'h7, {rd[10], rd[7], rd[6]})
    `CHK("busy write dropped", 8'h00, tx_data)
    `CHK("no load", 0, loads)
    axi_write(A_ST, 32'h0000_0000, 4'h3);
    rx_holding_full <= 1'b0;
    pulse(5'h10);
    axi_write(A_TX, 32'h0000_003c, 4'hf);
    axi_read(A_ST);
    `CHK("sticky clear", 3'h0, {rd[10], rd[7], rd[6]})
    `CHK("tx hold", 8'h3c, tx_data)
    `CHK("one load", 1, loads)
    axi_read(32'h0000_000c);
    `CHK("unmapped read", {i2c_stat_pkg::RESP_SLVERR, 32'h0}, {rsp, rd})
    axi_write(32'h0000_000c, 32'h0000_00ff, 4'hf);
    `CHK("unmapped write", i2c_stat_pkg::RESP_SLVERR, rsp)
    // second reset in mid-run returns the mask to zero
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    axi_read(A_MK);
    `CHK("mask second reset", 32'h0000_0000, rd)
    axi_read(A_ST);
    `CHK("status second reset", 32'h0000_0000, rd)
    `CHK("tx hold second reset", 8'h00, tx_data)
    print_verdict();
  end
endmodule
`default_nettype wire
